//--- pkg/psel_pkg.sv
// Shared constants and types for the potentiometer serial slave
package psel_pkg;

  // ****************************************************************
  // Register addresses and field layout
  // ****************************************************************
  localparam logic [7:0] POSITION_ADDR      = 8'h00;
  localparam logic [7:0] TARGET_SELECT_ADDR = 8'h02;
  localparam int         SEL_BIT            = 7;
  localparam int         BYTE_MSB           = 7;
  localparam int         POS_W              = 7;
  localparam logic [6:0] POS_MAX            = 7'h7f;
  localparam logic [6:0] POS_MIN            = 7'h00;
  localparam logic [6:0] POS_STEP           = 7'h01;
  localparam logic [6:0] STORED_RESET       = 7'h00;
  localparam logic       SEL_RESET          = 1'h1;

  // ****************************************************************
  // Slave address byte fields
  // ****************************************************************
  localparam int TYPE_W     = 5;
  localparam int TYPE_MSB   = 7;
  localparam int TYPE_LSB   = 3;
  localparam int PIN_HI_BIT = 2;
  localparam int PIN_LO_BIT = 1;
  localparam int RW_BIT     = 0;

  // ****************************************************************
  // Byte and bit counting
  // ****************************************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [1:0] BYTE_SLAVE    = 2'h0;
  localparam logic [1:0] BYTE_REG      = 2'h1;
  localparam logic [1:0] BYTE_DATA     = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int TMR_W                = 16;
  localparam int REF_CLK_PERIOD_NS    = 100;
  localparam int NV_PROGRAM_TIME_NS   = 5_000_000;
  localparam int WIPER_SETTLE_TIME_NS = 5_000;
  localparam int NV_PROGRAM_CYC       = NV_PROGRAM_TIME_NS / REF_CLK_PERIOD_NS;
  localparam int WIPER_SETTLE_CYC     =
    (WIPER_SETTLE_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

  // ****************************************************************
  // Protocol states, Gray coded along the usual path
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6,
    ST_WAIT = 3'h7,
    ST_STEP = 3'h5
  } psel_state_t;

endpackage : psel_pkg

//--- verilog/psel_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
module psel_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule : psel_sync

//--- verilog/psel_timer.sv
// One-shot down counter giving a busy level and a done pulse
module psel_timer
  import psel_pkg::*;
#(
  parameter int W = TMR_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Start request with length in cycles, at least one
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_count,
  // Status
  output logic              o_busy,
  output logic              o_done
);

  localparam logic [W-1:0] CNT_ONE = W'(1);

  logic [W-1:0] cnt_r;
  logic         busy_r;
  logic         done_r;

  // Start is ignored while running
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && i_start) begin
        cnt_r  <= i_count;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - CNT_ONE;
        if (cnt_r == CNT_ONE) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;

endmodule : psel_timer

//--- verilog/psel_slave.sv
// Two-wire slave front end of a nonvolatile digital potentiometer
// ****************************************************************
// Overview of operation
// - Start is SDA falling, SCL high
// - Stop is SDA rising, SCL high
// - SDA change with SCL high is start/stop
// - Receiver pulls SDA low on ninth clock
// - Acknowledge own address and written bytes
// - Read: send byte, no acknowledge ends
// - Stop after a write to 00h with stored selected starts blind program cycle
// - Address unacknowledged while program cycle runs
// - Register 02h selects wiper or stored
// - Upper five address bits match type code
// - Two address bits match address pins
// - Low address bit: one read, zero write
// - Wiper output follows once settle window ends
// - Position keeps seven bits, MSB reads zero
// - Register 00h write updates wiper position
// - Step mode moves wiper, saturating
// - Reset loads wiper from stored position
// ****************************************************************
module psel_slave
  import psel_pkg::*;
#(
  parameter int                P_NV_PROG_CYC = NV_PROGRAM_CYC,
  parameter int                P_SETTLE_CYC  = WIPER_SETTLE_CYC,
  // Type codes below are arbitrary values
  parameter logic [TYPE_W-1:0] P_TYPE_CODE   = 5'h13,
  parameter logic [TYPE_W-1:0] P_STEP_CODE   = 5'h17
) (
  // Clock and reset
  input  wire logic             I_REF_CLK,
  input  wire logic             I_RST,
  // Two-wire bus
  input  wire logic             I_SCL,
  input  wire logic             I_SDA,
  output logic                  O_SDA_OUT,
  output logic                  O_SDA_OE_N,
  // Address select pins
  input  wire logic             I_ADDR_PIN_HI,
  input  wire logic             I_ADDR_PIN_LO,
  // Potentiometer side
  output logic      [POS_W-1:0] O_WIPER_POS,
  output logic                  O_NV_BUSY
);

  // ****************************************************************
  // Pin synchronisation and bus events
  // ****************************************************************
  logic [3:0] pin_s;
  logic       scl_d_r;
  logic       sda_d_r;
  wire        scl_s;
  wire        sda_s;
  wire        pin_hi_s;
  wire        pin_lo_s;

  psel_sync #(.W(4)) u_pin_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_async ({I_SCL, I_SDA, I_ADDR_PIN_HI, I_ADDR_PIN_LO}),
    .o_sync  (pin_s)
  );

  assign scl_s    = pin_s[3];
  assign sda_s    = pin_s[2];
  assign pin_hi_s = pin_s[1];
  assign pin_lo_s = pin_s[0];

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ****************************************************************
  // State and decode
  // ****************************************************************
  psel_state_t      state_r;
  psel_state_t      state_nxt;
  logic [3:0]       bit_cnt_r;
  logic [3:0]       bit_cnt_nxt;
  logic [1:0]       byte_idx_r;
  logic [1:0]       byte_idx_nxt;
  logic [7:0]       shift_r;
  logic [7:0]       tx_shift_r;
  logic [7:0]       reg_addr_r;
  logic             rd_mode_r;
  logic             inc_mode_r;
  logic             sel_wiper_r;
  logic [POS_W-1:0] wiper_reg_r;
  logic [POS_W-1:0] stored_reg_r;
  logic [POS_W-1:0] nv_data_r;
  logic [POS_W-1:0] wiper_out_r;
  logic             nv_pend_r;
  logic             load_pend_r;
  logic             oe_n_r;
  logic             sda_out_r;
  logic             nv_busy;
  logic             settle_busy;
  logic             settle_done;

  wire rx_done   = (state_r == ST_RX) && scl_fall && (bit_cnt_r == BITS_PER_BYTE);
  wire type_hit  = shift_r[TYPE_MSB:TYPE_LSB] == P_TYPE_CODE;
  wire step_hit  = (shift_r[TYPE_MSB:TYPE_LSB] == P_STEP_CODE) && !shift_r[RW_BIT];
  wire pin_hit   = (shift_r[PIN_HI_BIT] == pin_hi_s) &&
                   (shift_r[PIN_LO_BIT] == pin_lo_s);
  wire addr_hit  = pin_hit && (type_hit || step_hit);
  wire rx_ack    = rx_done && ((byte_idx_r != BYTE_SLAVE) || addr_hit);
  wire slave_rx  = rx_done && (byte_idx_r == BYTE_SLAVE);
  wire reg_wr    = rx_done && (byte_idx_r == BYTE_REG) && !rd_mode_r;
  wire data_wr   = rx_done && (byte_idx_r == BYTE_DATA) && !rd_mode_r;
  wire tsel_wr   = data_wr && (reg_addr_r == TARGET_SELECT_ADDR);
  wire pos_wr    = data_wr && (reg_addr_r == POSITION_ADDR);
  wire step_ev   = (state_r == ST_STEP) && scl_rise;
  wire nv_start  = stop_ev && nv_pend_r && !nv_busy;
  wire tx_load   = scl_fall && (((state_r == ST_ACK) && rd_mode_r) || (state_r == ST_MACK));
  wire tx_shift  = scl_fall && (state_r == ST_TX) && (bit_cnt_r != BIT_LAST);
  wire [7:0] rd_data = {1'b0, sel_wiper_r ? wiper_reg_r : stored_reg_r};
  wire [7:0] tx_shift_nxt = tx_load  ? rd_data :
                            tx_shift ? {tx_shift_r[6:0], 1'b0} : tx_shift_r;
  wire [POS_W-1:0] step_val = sda_s ?
    ((wiper_reg_r == POS_MAX) ? wiper_reg_r : wiper_reg_r + POS_STEP) :
    ((wiper_reg_r == POS_MIN) ? wiper_reg_r : wiper_reg_r - POS_STEP);
  wire settle_go = (wiper_reg_r != wiper_out_r) && !settle_busy && !settle_done;

  // ****************************************************************
  // Protocol sequencing
  // ****************************************************************
  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    byte_idx_nxt = byte_idx_r;
    if (nv_busy) begin
      state_nxt = ST_IDLE;
    end else if (start_ev) begin
      state_nxt    = ST_RX;
      bit_cnt_nxt  = '0;
      byte_idx_nxt = BYTE_SLAVE;
    end else if (stop_ev) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_WAIT, ST_STEP: begin
          state_nxt = state_r;
        end
        ST_RX: begin
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (rx_done) begin
            state_nxt = rx_ack ? ST_ACK : ST_WAIT;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_nxt  = '0;
            byte_idx_nxt = (byte_idx_r == BYTE_DATA) ? BYTE_DATA : byte_idx_r + 2'h1;
            if (rd_mode_r) begin
              state_nxt = ST_TX;
            end else if (inc_mode_r && (byte_idx_r == BYTE_REG)) begin
              state_nxt = ST_STEP;
            end else begin
              state_nxt = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == BIT_LAST) begin
              state_nxt = ST_MACK;
            end else begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s) begin
            state_nxt = ST_WAIT;
          end else if (scl_fall) begin
            state_nxt   = ST_TX;
            bit_cnt_nxt = '0;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Open drain: pull low for acknowledge or a zero data bit
  wire drive_nxt = (state_nxt == ST_ACK) ||
                   ((state_nxt == ST_TX) && !tx_shift_nxt[BYTE_MSB]);

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= '0;
      byte_idx_r <= BYTE_SLAVE;
      oe_n_r     <= 1'b1;
      sda_out_r  <= 1'b0;
      tx_shift_r <= '0;
    end else begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      oe_n_r     <= ~drive_nxt;
      sda_out_r  <= 1'b0;
      tx_shift_r <= tx_shift_nxt;
    end
  end

  // ****************************************************************
  // Received bytes and command decode
  // ****************************************************************
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      shift_r    <= '0;
      rd_mode_r  <= 1'b0;
      inc_mode_r <= 1'b0;
      reg_addr_r <= POSITION_ADDR;
    end else begin
      if ((state_r == ST_RX) && scl_rise) begin
        shift_r <= {shift_r[6:0], sda_s};
      end
      if (slave_rx) begin
        rd_mode_r  <= shift_r[RW_BIT] && type_hit;
        inc_mode_r <= step_hit;
      end
      if (reg_wr) begin
        reg_addr_r <= shift_r;
      end
    end
  end

  // ****************************************************************
  // Target select, wiper and stored position
  // ****************************************************************
  // Select register is write only; a read returns the chosen position
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      sel_wiper_r <= SEL_RESET;
    end else if (tsel_wr) begin
      sel_wiper_r <= shift_r[SEL_BIT];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      load_pend_r <= 1'b1;
      wiper_reg_r <= STORED_RESET;
    end else begin
      load_pend_r <= 1'b0;
      if (load_pend_r) begin
        wiper_reg_r <= stored_reg_r;
      end else if (pos_wr) begin
        wiper_reg_r <= shift_r[POS_W-1:0];
      end else if (step_ev) begin
        wiper_reg_r <= step_val;
      end
    end
  end

  // Stored value is committed only by the stop that ends the write
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      nv_pend_r    <= 1'b0;
      nv_data_r    <= STORED_RESET;
      stored_reg_r <= STORED_RESET;
    end else begin
      if (pos_wr && !sel_wiper_r) begin
        nv_pend_r <= 1'b1;
        nv_data_r <= shift_r[POS_W-1:0];
      end else if (start_ev || nv_start) begin
        nv_pend_r <= 1'b0;
      end
      if (nv_start) begin
        stored_reg_r <= nv_data_r;
      end
    end
  end

  psel_timer #(.W(TMR_W)) u_nv_timer (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_start (nv_start),
    .i_count (TMR_W'(P_NV_PROG_CYC)),
    .o_busy  (nv_busy),
    .o_done  ()
  );

  // Output follows after a settle delay; steps made during a window are taken at its end
  psel_timer #(.W(TMR_W)) u_settle_timer (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_start (settle_go),
    .i_count (TMR_W'(P_SETTLE_CYC)),
    .o_busy  (settle_busy),
    .o_done  (settle_done)
  );

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      wiper_out_r <= STORED_RESET;
    end else if (settle_done) begin
      wiper_out_r <= wiper_reg_r;
    end
  end

  assign O_SDA_OUT   = sda_out_r;
  assign O_SDA_OE_N  = oe_n_r;
  assign O_WIPER_POS = wiper_out_r;
  assign O_NV_BUSY   = nv_busy;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb_ref @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  property p_idle_hold;
    (state_r == ST_IDLE) && !start_ev |=> (state_r == ST_IDLE);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Left idle without start");

  property p_stop_idle;
    stop_ev |=> (state_r == ST_IDLE) && O_SDA_OE_N;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop did not release");

  property p_ack_low;
    (state_r == ST_ACK) |-> !O_SDA_OE_N;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("Acknowledge not driven");

  property p_ack_write;
    rx_done && (byte_idx_r != BYTE_SLAVE) |=> (state_r == ST_ACK);
  endproperty
  a_ack_write: assert property (p_ack_write) else $error("Written byte not acked");

  property p_mack_nak;
    (state_r == ST_MACK) && scl_rise && sda_s && !nv_busy |=> (state_r == ST_WAIT) [*2];
  endproperty
  a_mack_nak: assert property (p_mack_nak) else $error("Sent on after no ack");

  property p_busy_start;
    $rose(O_NV_BUSY) |-> $past(stop_ev) && (stored_reg_r == $past(nv_data_r));
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("Program cycle bad start");

  property p_busy_quiet;
    O_NV_BUSY |=> O_SDA_OE_N && (state_r == ST_IDLE);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("Bus answered while busy");

  property p_tsel;
    tsel_wr |=> (sel_wiper_r == $past(shift_r[SEL_BIT]));
  endproperty
  a_tsel: assert property (p_tsel) else $error("Target select not stored");

  property p_addr_miss;
    slave_rx && !addr_hit |=> (state_r == ST_WAIT) && O_SDA_OE_N;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("Foreign address acked");

  property p_wiper_settle;
    $changed(O_WIPER_POS) |-> $past(settle_done) && !$past(settle_done, 2);
  endproperty
  a_wiper_settle: assert property (p_wiper_settle) else $error("Wiper moved early");

  property p_msb_zero;
    tx_load |=> !tx_shift_r[BYTE_MSB];
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("Read MSB not zero");

  property p_saturate;
    step_ev && sda_s && (wiper_reg_r == POS_MAX) |=> (wiper_reg_r == POS_MAX);
  endproperty
  a_saturate: assert property (p_saturate) else $error("Wiper wrapped at top");

  property p_recall;
    $fell(load_pend_r) |-> (wiper_reg_r == stored_reg_r);
  endproperty
  a_recall: assert property (p_recall) else $error("Wiper not recalled");

  c_read_more: cover property ((state_r == ST_MACK) ##1 (state_r == ST_TX));
  c_nv_cycle:  cover property ($fell(O_NV_BUSY));
  c_step:      cover property (step_ev);
  c_addr_miss: cover property (slave_rx && !addr_hit);

endmodule : psel_slave

//--- testbench/psel_master_model.sv
// Two-wire bus master model that drives the slave's bus pins
module psel_master_model (
  // Clock
  input  wire logic i_clk,
  // Bus lines, data is open drain
  output logic      o_scl,
  output logic      o_sda_oe_n,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Bus primitives, all paced on the falling clock edge
  // ****************************************************************
  initial begin
    o_scl      = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt

  // Data moves only while the clock is low
  task automatic put_bit(input logic b);
    o_scl = 1'b0;
    wt(2);
    o_sda_oe_n = b;
    wt(6);
    o_scl = 1'b1;
    wt(6);
  endtask : put_bit

  task automatic get_bit(output logic b);
    o_scl = 1'b0;
    wt(2);
    o_sda_oe_n = 1'b1;
    wt(6);
    o_scl = 1'b1;
    wt(3);
    b = i_sda;
    wt(3);
  endtask : get_bit

  // Clock goes low first, so a repeated start never looks like a stop
  task automatic start_c();
    o_scl = 1'b0;
    wt(2);
    o_sda_oe_n = 1'b1;
    wt(6);
    o_scl = 1'b1;
    wt(6);
    o_sda_oe_n = 1'b0;
    wt(6);
  endtask : start_c

  task automatic stop_c();
    o_scl = 1'b0;
    wt(2);
    o_sda_oe_n = 1'b0;
    wt(6);
    o_scl = 1'b1;
    wt(6);
    o_sda_oe_n = 1'b1;
    wt(6);
  endtask : stop_c

  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask : send_byte

  // Acknowledge low keeps a read going, high ends it
  task automatic recv_byte(input logic mack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(mack);
  endtask : recv_byte
endmodule : psel_master_model

//--- testbench/psel_slave_tb_top.sv
// Self-checking bench for the potentiometer serial slave
module psel_slave_tb_top
  import psel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Settings, a short program cycle keeps the run brief
  // ****************************************************************
  localparam int                NV_CYC  = 400;
  localparam int                SET_CYC = 3;
  localparam int                LIMIT   = 40000;
  // Type codes below are arbitrary values
  localparam logic [TYPE_W-1:0] TCODE   = 5'h13;
  localparam logic [TYPE_W-1:0] SCODE   = 5'h17;

  logic             clk;
  logic             rst;
  logic             pin_hi;
  logic             pin_lo;
  logic             scl;
  logic             m_oe_n;
  logic             sda_out;
  logic             sda_oe_n;
  logic             sda;
  logic [POS_W-1:0] wiper;
  logic             busy;
  logic [15:0]      busy_cnt;
  logic [15:0]      busy_len;
  int               cyc;
  int               bad_count;
  int               checks;
  logic             ack;
  logic [7:0]       rd;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Open-drain wire with pull-up
  assign sda = !m_oe_n ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);

  psel_slave #(
    .P_NV_PROG_CYC (NV_CYC),
    .P_SETTLE_CYC  (SET_CYC),
    .P_TYPE_CODE   (TCODE),
    .P_STEP_CODE   (SCODE)
  ) dut (
    .I_REF_CLK     (clk),
    .I_RST         (rst),
    .I_SCL         (scl),
    .I_SDA         (sda),
    .O_SDA_OUT     (sda_out),
    .O_SDA_OE_N    (sda_oe_n),
    .I_ADDR_PIN_HI (pin_hi),
    .I_ADDR_PIN_LO (pin_lo),
    .O_WIPER_POS   (wiper),
    .O_NV_BUSY     (busy)
  );

  psel_master_model master (
    .i_clk      (clk),
    .o_scl      (scl),
    .o_sda_oe_n (m_oe_n),
    .i_sda      (sda)
  );

  // ****************************************************************
  // Busy length monitor and hang guard
  // ****************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy) begin
      busy_cnt <= busy_cnt + 16'h1;
    end else if (busy_cnt != 16'h0) begin
      busy_len <= busy_cnt;
      busy_cnt <= 16'h0;
    end
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic give_verdict();
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] addr(input logic [4:0] code, input logic rw);
    return {code, pin_hi, pin_lo, rw};
  endfunction : addr

  task automatic send_chk(input logic [7:0] d, input logic exp_ack);
    master.send_byte(d, ack);
    check({15'h0, ack}, {15'h0, exp_ack});
  endtask : send_chk

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    master.start_c();
    send_chk(addr(TCODE, 1'b0), 1'b0);
    send_chk(a, 1'b0);
    send_chk(d, 1'b0);
    master.stop_c();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic mack);
    master.start_c();
    send_chk(addr(TCODE, 1'b0), 1'b0);
    send_chk(a, 1'b0);
    master.start_c();
    send_chk(addr(TCODE, 1'b1), 1'b0);
    master.recv_byte(mack, rd);
  endtask : reg_read

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check({15'h0, sda_oe_n}, 16'h1);
    check({9'h0, wiper}, 16'h0);
    check({15'h0, busy}, 16'h0);
  endtask : t_reset

  task automatic t_no_start();
    send_chk(addr(TCODE, 1'b0), 1'b1);
    master.stop_c();
  endtask : t_no_start

  task automatic t_wiper();
    reg_write(8'h02, 8'h80);
    reg_write(8'h00, 8'hd5);
    master.wt(SET_CYC + 4);
    check({9'h0, wiper}, 16'h0055);
    check({15'h0, busy}, 16'h0);
  endtask : t_wiper

  task automatic t_read();
    reg_read(8'h00, 1'b0);
    check({8'h0, rd}, 16'h0055);
    master.recv_byte(1'b1, rd);
    check({8'h0, rd}, 16'h0055);
    master.recv_byte(1'b1, rd);
    check({8'h0, rd}, 16'h00ff);
    master.stop_c();
  endtask : t_read

  task automatic t_step();
    master.start_c();
    send_chk(addr(SCODE, 1'b0), 1'b0);
    send_chk(8'h00, 1'b0);
    repeat (50) master.put_bit(1'b1);
    master.wt(SET_CYC + 4);
    check({9'h0, wiper}, 16'h007f);
    repeat (130) master.put_bit(1'b0);
    master.wt(SET_CYC + 4);
    check({9'h0, wiper}, 16'h0000);
    repeat (3) master.put_bit(1'b1);
    master.wt(SET_CYC + 4);
    check({9'h0, wiper}, 16'h0003);
    master.stop_c();
  endtask : t_step

  task automatic t_addr();
    logic [7:0] bad [4];
    bad[0] = addr(TCODE ^ 5'h01, 1'b0);
    bad[1] = addr(TCODE, 1'b0) ^ 8'h04;
    bad[2] = addr(TCODE, 1'b0) ^ 8'h02;
    bad[3] = addr(SCODE, 1'b1);
    for (int i = 0; i < 4; i++) begin
      master.start_c();
      send_chk(bad[i], 1'b1);
      master.stop_c();
    end
    for (int i = 0; i < 4; i++) begin
      {pin_hi, pin_lo} = 2'(i);
      master.wt(4);
      master.start_c();
      send_chk(addr(TCODE, 1'b0), 1'b0);
      master.stop_c();
    end
  endtask : t_addr

  task automatic t_stored();
    int n;
    reg_write(8'h02, 8'h00);
    reg_write(8'h00, 8'h2a);
    check({15'h0, busy}, 16'h1);
    n = 0;
    ack = 1'b1;
    while (ack && n < 8) begin
      master.start_c();
      master.send_byte(addr(TCODE, 1'b0), ack);
      master.stop_c();
      if (n == 0) begin
        check({15'h0, ack}, 16'h1);
      end
      n++;
    end
    check({15'h0, ack}, 16'h0);
    check(busy_len, 16'(NV_CYC));
    reg_read(8'h00, 1'b1);
    master.stop_c();
    check({8'h0, rd}, 16'h002a);
    check({9'h0, wiper}, 16'h002a);
  endtask : t_stored

  initial begin
    rst       = 1'b1;
    pin_hi    = 1'b0;
    pin_lo    = 1'b0;
    cyc       = 0;
    bad_count = 0;
    checks    = 0;
    busy_cnt  = 16'h0;
    busy_len  = 16'h0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    t_reset();
    t_no_start();
    t_wiper();
    t_read();
    t_step();
    t_addr();
    t_stored();
    give_verdict();
  end
endmodule : psel_slave_tb_top
